// >>> core/adc_ctl_pkg.sv
package adc_ctl_pkg;

    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_MODE = 4'h0;
    localparam logic [3:0] IDX_TRIG = 4'h1;
    localparam logic [3:0] IDX_FILT_BASE = 4'h2;
    localparam logic [3:0] IDX_CONFIG = 4'h8;
    localparam logic [3:0] IDX_IRQ = 4'h9;
    localparam int NUM_FILT = 6;

    // Input mode register: pair flags at odd bits, sign flags at even bits
    localparam logic [31:0] MODE_MASK = 32'h00ff_ffff;
    localparam logic [31:0] MODE_RESET = 32'h0000_0000;
    // Trigger register: four 5-bit fields
    localparam logic [31:0] TRIG_MASK = 32'h1f1f_1f1f;
    localparam logic [31:0] TRIG_RESET = 32'h0000_0000;
    localparam int TRIG_W = 5;
    localparam int TRIG_STRIDE = 8;

    // Filter register fields
    localparam int F_ON = 31;
    localparam int F_FULL = 30;
    localparam int F_KIND = 29;
    localparam int F_RATIO_LO = 26;
    localparam int F_IRQ = 25;
    localparam int F_VALID = 24;
    localparam int F_SEL_LO = 16;
    localparam logic [31:0] FILT_CTL_MASK = 32'hfe1f_0000;
    localparam logic [31:0] FILT_RESET = 32'h0000_0000;

    // Config register: fractional output at bit 0
    localparam int CFG_FRACTIONAL_OUTPUT = 0;

    // Trigger codes
    localparam logic [4:0] TRG_NONE = 5'h00;
    localparam logic [4:0] TRG_SW_EDGE = 5'h01;
    localparam logic [4:0] TRG_SW_LEVEL = 5'h02;
    localparam logic [4:0] TRG_SCAN = 5'h03;
    localparam logic [4:0] TRG_TMR1 = 5'h05;
    localparam logic [4:0] TRG_TMR3 = 5'h06;
    localparam logic [4:0] TRG_TIMER_FIVE = 5'h07;
    localparam logic [4:0] TRG_OC1 = 5'h08;
    localparam logic [4:0] TRG_OC3 = 5'h09;
    localparam logic [4:0] TRG_OC5 = 5'h0a;
    localparam logic [4:0] TRG_CMP1 = 5'h0b;
    localparam logic [4:0] TRG_CMP2 = 5'h0c;
    localparam logic [4:0] TRG_CTU_A = 5'h0d;
    localparam logic [4:0] TRG_CTU_B = 5'h1d;

    typedef enum logic {KIND_OVERSAMPLE, KIND_AVERAGE} filter_kind_t;

    // Register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // One conversion result from the core
    typedef struct packed {
        logic valid;
        logic [5:0] input_id;
        logic [11:0] data;
    } conv_result_t;

    // Event sources from peripherals
    typedef struct packed {
        logic global_edge_soft_trigger;
        logic global_level_soft_trigger;
        logic scan_trigger;
        logic timer_one;
        logic timer_three;
        logic timer_five;
        logic compare_unit_one;
        logic compare_unit_three;
        logic compare_unit_five;
        logic comparator_one_output;
        logic comparator_two_output;
        logic charge_time_unit;
    } trig_src_t;

endpackage

// >>> core/adc_filter_trigger_control.sv
`timescale 1ns/1ps
module adc_filter_trigger_control (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Register port
    input wire adc_ctl_pkg::reg_req_t reg_req,
    output logic [31:0] reg_rdata,
    // Conversion core
    input wire adc_ctl_pkg::conv_result_t conv_in,
    input wire adc_ctl_pkg::trig_src_t trig_src,
    output logic [11:0] input_pair_mode,
    output logic [11:0] twos_complement_select,
    output logic [3:0] conv_start,
    // Filter interrupts
    output logic [5:0] filter_irq
);
    import adc_ctl_pkg::*;

    logic [31:0] mode_reg;
    logic [31:0] trig_reg;
    logic [31:0] cfg_reg;
    logic [31:0] filt_ctl [NUM_FILT];
    logic [15:0] filt_res [NUM_FILT];
    logic [23:0] filt_acc [NUM_FILT];
    logic [8:0] filt_cnt [NUM_FILT];
    wire [5:0] next_irq;

    wire wr_mode = reg_req.wr && reg_req.addr == IDX_MODE;
    wire wr_trig = reg_req.wr && reg_req.addr == IDX_TRIG;
    wire wr_cfg = reg_req.wr && reg_req.addr == IDX_CONFIG;
    wire fractional_output = cfg_reg[CFG_FRACTIONAL_OUTPUT];

    function automatic logic [8:0] ratio_count(input logic kind, input logic [2:0] r);
        logic [8:0] n;
        n = 9'h000;
        if (kind) begin
            n = 9'(2 << r);
        end else begin
            case (r)
                3'h0: n = 9'h004;
                3'h1: n = 9'h010;
                3'h2: n = 9'h040;
                3'h3: n = 9'h100;
                3'h4: n = 9'h002;
                3'h5: n = 9'h008;
                3'h6: n = 9'h020;
                default: n = 9'h080;
            endcase
        end
        return n;
    endfunction

    // Mean of 2 to 256 samples is the sum shifted right by code plus one
    function automatic logic [3:0] avg_shift(input logic [2:0] r);
        return {1'b0, r} + 4'h1;
    endfunction

    // oversample shift; codes 4-7 keep one fraction bit
    function automatic logic [3:0] ovs_shift(input logic [2:0] r);
        logic [3:0] s;
        s = {2'b00, r[1:0]};
        if (!r[2]) begin
            s = s + 4'h1;
        end
        return s;
    endfunction

    // Final result from the completed sum
    function automatic logic [15:0] finish(input logic [31:0] ctl, input logic [23:0] sum,
                                           input logic fr);
        logic [2:0] r;
        logic [23:0] v;
        logic [27:0] x;
        logic [15:0] o;
        r = ctl[F_RATIO_LO +: 3];
        v = 24'h000000;
        x = 28'h0000000;
        o = 16'h0000;
        if (ctl[F_KIND] == KIND_AVERAGE) begin
            v = sum >> avg_shift(r);
            // Four more bits of the mean, kept only for the full-width option
            x = {sum, 4'h0} >> avg_shift(r);
            if (fr && ctl[F_FULL]) begin
                o = x[15:0];
            end else if (fr) begin
                o = {v[11:0], 4'h0};
            end else begin
                o = 16'(v[11:0]);
            end
        end else if (r[2]) begin
            v = sum >> ovs_shift(r);
            o = v[15:0];
        end else begin
            v = sum >> ovs_shift(r);
            o = v[15:0];
        end
        return o;
    endfunction

    // shared decode for all four fields
    function automatic logic pick(input logic [4:0] code, input trig_src_t s,
                                  input logic [2:0] rise);
        logic t;
        t = 1'b0;
        case (code)
            TRG_NONE: t = 1'b0;
            TRG_SW_EDGE: t = s.global_edge_soft_trigger;
            TRG_SW_LEVEL: t = s.global_level_soft_trigger;
            TRG_SCAN: t = s.scan_trigger;
            TRG_TMR1: t = s.timer_one;
            TRG_TMR3: t = s.timer_three;
            TRG_TIMER_FIVE: t = s.timer_five;
            TRG_OC1: t = rise[0];
            TRG_OC3: t = rise[1];
            TRG_OC5: t = rise[2];
            TRG_CMP1: t = s.comparator_one_output & ~s.compare_unit_one & 1'b0;
            TRG_CMP2: t = 1'b0;
            TRG_CTU_A: t = s.charge_time_unit;
            TRG_CTU_B: t = s.charge_time_unit;
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    // Rising edges of compare units and comparators
    // Previous levels reset to the idle low level, so reset makes no false edge
    wire [4:0] lvl = {trig_src.comparator_two_output, trig_src.comparator_one_output,
                      trig_src.compare_unit_five, trig_src.compare_unit_three,
                      trig_src.compare_unit_one};
    logic [4:0] lvl_prev;
    wire [4:0] rise = lvl & ~lvl_prev;

    logic [3:0] next_start;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            next_start[i] = pick(trig_reg[i*TRIG_STRIDE +: TRIG_W], trig_src, rise[2:0]);
            if (trig_reg[i*TRIG_STRIDE +: TRIG_W] == TRG_CMP1) begin
                next_start[i] = rise[3];
            end else if (trig_reg[i*TRIG_STRIDE +: TRIG_W] == TRG_CMP2) begin
                next_start[i] = rise[4];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            lvl_prev <= 5'h00;
            conv_start <= 4'h0;
        end else begin
            lvl_prev <= lvl;
            conv_start <= next_start;
        end
    end

    // Control registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mode_reg <= MODE_RESET;
            trig_reg <= TRIG_RESET;
            cfg_reg <= 32'h0000_0000;
        end else begin
            if (wr_mode) begin
                mode_reg <= reg_req.wdata & MODE_MASK;
            end
            if (wr_trig) begin
                trig_reg <= reg_req.wdata & TRIG_MASK;
            end
            if (wr_cfg) begin
                cfg_reg <= {31'h0, reg_req.wdata[CFG_FRACTIONAL_OUTPUT]};
            end
        end
    end

    logic [11:0] next_pair;
    logic [11:0] next_sign;
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            next_pair[i] = mode_reg[2*i+1];
            next_sign[i] = mode_reg[2*i];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            input_pair_mode <= 12'h000;
            twos_complement_select <= 12'h000;
        end else begin
            input_pair_mode <= next_pair;
            twos_complement_select <= next_sign;
        end
    end

    for (genvar f = 0; f < NUM_FILT; f++) begin : g_filt
        wire wr_f = reg_req.wr && reg_req.addr == 4'(IDX_FILT_BASE + f);
        wire rd_f = reg_req.rd && reg_req.addr == 4'(IDX_FILT_BASE + f);
        wire on = filt_ctl[f][F_ON];
        wire hit = on && conv_in.valid &&
                   conv_in.input_id == {1'b0, filt_ctl[f][F_SEL_LO +: 5]};
        wire [8:0] need = ratio_count(filt_ctl[f][F_KIND], filt_ctl[f][F_RATIO_LO +: 3]);
        wire last = hit && (filt_cnt[f] + 9'h001 == need);
        wire [23:0] sum = filt_acc[f] + 24'(conv_in.data);

        always_ff @(posedge sys_clk) begin
            if (srst) begin
                filt_ctl[f] <= FILT_RESET;
                filt_res[f] <= 16'h0000;
                filt_acc[f] <= 24'h000000;
                filt_cnt[f] <= 9'h000;
            end else begin
                if (wr_f) begin
                    filt_ctl[f] <= (reg_req.wdata & FILT_CTL_MASK) |
                                   {7'h0, filt_ctl[f][F_VALID], 24'h0};
                    filt_acc[f] <= 24'h000000;
                    filt_cnt[f] <= 9'h000;
                    if (!reg_req.wdata[F_ON]) begin
                        filt_ctl[f][F_VALID] <= 1'b0;
                    end else if (last) begin
                        filt_ctl[f][F_VALID] <= 1'b1;
                        filt_res[f] <= finish(filt_ctl[f], sum, fractional_output);
                    end
                end else begin
                    if (!on) begin
                        filt_acc[f] <= 24'h000000;
                        filt_cnt[f] <= 9'h000;
                    end else if (last) begin
                        filt_acc[f] <= 24'h000000;
                        filt_cnt[f] <= 9'h000;
                        filt_res[f] <= finish(filt_ctl[f], sum, fractional_output);
                    end else if (hit) begin
                        filt_acc[f] <= sum;
                        filt_cnt[f] <= filt_cnt[f] + 9'h001;
                    end
                    // read clears valid; a new result wins
                    if (last) begin
                        filt_ctl[f][F_VALID] <= 1'b1;
                    end else if (rd_f) begin
                        filt_ctl[f][F_VALID] <= 1'b0;
                    end
                end
            end
        end

        assign next_irq[f] = filt_ctl[f][F_IRQ] & filt_ctl[f][F_VALID];
    end

    // One process owns every interrupt bit
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            filter_irq <= 6'h00;
        end else begin
            filter_irq <= next_irq;
        end
    end

    // Read mux; unmapped reads return zero
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (reg_req.rd) begin
            if (reg_req.addr == IDX_MODE) begin
                next_rdata = mode_reg;
            end else if (reg_req.addr == IDX_TRIG) begin
                next_rdata = trig_reg;
            end else if (reg_req.addr == IDX_CONFIG) begin
                next_rdata = cfg_reg;
            end else if (reg_req.addr == IDX_IRQ) begin
                next_rdata = {26'h0, filter_irq};
            end else begin
                for (int i = 0; i < NUM_FILT; i++) begin
                    if (reg_req.addr == 4'(IDX_FILT_BASE + i)) begin
                        next_rdata = filt_ctl[i] | {16'h0, filt_res[i]};
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule

// >>> test/adc_ctl_asserts.sv
`timescale 1ns/1ps
module adc_ctl_asserts
    import adc_ctl_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Watched ports
    input wire adc_ctl_pkg::reg_req_t reg_req,
    input wire logic [31:0] reg_rdata,
    input wire adc_ctl_pkg::conv_result_t conv_in,
    input wire adc_ctl_pkg::trig_src_t trig_src,
    input wire logic [11:0] input_pair_mode,
    input wire logic [11:0] twos_complement_select,
    input wire logic [3:0] conv_start,
    input wire logic [5:0] filter_irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    function automatic logic [11:0] pick(logic [31:0] w, int o);
        for (int i = 0; i < 12; i++) begin
            pick[i] = w[2 * i + o];
        end
    endfunction
    sequence s_mode_wr;
        reg_req.wr && reg_req.addr == IDX_MODE;
    endsequence
    sequence s_rd(logic [3:0] a);
        reg_req.rd && reg_req.addr == a;
    endsequence
    property p_mode(int o);
        logic [31:0] w;
        (s_mode_wr, w = reg_req.wdata) |->
            ##2 (o ? input_pair_mode : twos_complement_select) == pick(w, o);
    endproperty
    a_pair_mode_track: assert property (p_mode(1))
        else $error("pair mode output differs from written bits");
    a_sign_mode_track: assert property (p_mode(0))
        else $error("sign mode output differs from written bits");
    a_trig_unused_zero: assert property (s_rd(IDX_TRIG) |=> (reg_rdata & ~TRIG_MASK) == 0)
        else $error("unused trigger bits read nonzero");
    a_mode_unused_zero: assert property (s_rd(IDX_MODE) |=> (reg_rdata & ~MODE_MASK) == 0)
        else $error("unused mode bits read nonzero");
    a_unmapped_reads_zero: assert property (reg_req.rd && reg_req.addr > IDX_IRQ |=> reg_rdata == 0)
        else $error("unmapped read nonzero");
    a_start_has_cause: assert property (conv_start != 4'h0 |->
        $past(trig_src) != '0 || $past(trig_src, 2) != '0)
        else $error("conversion start without any source");
    for (genvar g = 0; g < NUM_FILT; g++) begin : g_filt
        sequence s_quiet;
            reg_req.wr && reg_req.addr == IDX_FILT_BASE + g &&
                !(reg_req.wdata[F_ON] && reg_req.wdata[F_IRQ]);
        endsequence
        a_irq_quiet_write: assert property (s_quiet |-> ##2 !filter_irq[g])
            else $error("filter interrupt while disabled");
        a_irq_from_done: assert property ($rose(filter_irq[g]) |->
            $past(conv_in.valid) || $past(conv_in.valid, 2) || $past(reg_req.wr, 2))
            else $error("filter interrupt without a completed result");
    end
endmodule
bind adc_filter_trigger_control adc_ctl_asserts u_adc_ctl_asserts (
    .sys_clk, .srst, .reg_req, .reg_rdata, .conv_in, .trig_src,
    .input_pair_mode, .twos_complement_select, .conv_start, .filter_irq
);

// >>> test/adc_core_model.sv
`timescale 1ns/1ps
module adc_core_model (
    // Clock
    input wire logic sys_clk,
    // Toward the block
    output adc_ctl_pkg::conv_result_t conv_in,
    output adc_ctl_pkg::trig_src_t trig_src
);
    import adc_ctl_pkg::*;
    initial begin
        conv_in = '0;
        trig_src = '0;
    end
    // Data line shows the inverse once the pulse ends, never the last result
    task automatic send(logic [5:0] id, logic [11:0] d);
        @(posedge sys_clk);
        conv_in <= '{1'b1, id, d};
        @(posedge sys_clk);
        conv_in.valid <= 1'b0;
        conv_in.data <= ~d;
    endtask
    // scan_trigger stands for a scan already set up at the far side
    task automatic fire(int b, int n);
        @(posedge sys_clk);
        trig_src[b] <= 1'b1;
        repeat (n) @(posedge sys_clk);
        trig_src[b] <= 1'b0;
    endtask
endmodule

// >>> test/test_adc_filter_trigger_control.sv
`timescale 1ns/1ps
module test_adc_filter_trigger_control;
    import adc_ctl_pkg::*;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    reg_req_t reg_req = '0;
    logic [31:0] reg_rdata;
    conv_result_t conv_in;
    trig_src_t trig_src;
    logic [11:0] input_pair_mode;
    logic [11:0] twos_complement_select;
    logic [3:0] conv_start;
    logic [5:0] filter_irq;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h30df;
    logic [7:0] hit [4];
    logic [4:0] tc [13] = '{5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
        5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h1d};
    always #20 sys_clk = ~sys_clk;
    adc_filter_trigger_control u_adc_filter_trigger_control (.sys_clk, .srst, .reg_req,
        .reg_rdata, .conv_in, .trig_src, .input_pair_mode, .twos_complement_select,
        .conv_start, .filter_irq);
    adc_core_model u_adc_core_model (.sys_clk, .conv_in, .trig_src);
    always @(posedge sys_clk) begin
        for (int j = 0; j < 4; j++) begin
            hit[j] <= hit[j] + conv_start[j];
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [11:0] pick(logic [31:0] w, int o);
        for (int i = 0; i < 12; i++) begin
            pick[i] = w[2 * i + o];
        end
    endfunction
    function automatic int ns(logic k, logic [2:0] r);
        if (k) return 2 << r;
        return r[2] ? 2 << (2 * (r - 4)) : 4 << (2 * r);
    endfunction
    function automatic logic [15:0] exp_res(logic k, logic [2:0] r, logic fr, logic fw,
        logic [31:0] s);
        logic [11:0] a;
        a = 12'(s >> (32'(r) + 1));
        if (k && fr && fw) return 16'((s << 4) >> (32'(r) + 1));
        if (k) return fr ? {a, 4'h0} : {4'h0, a};
        return 16'(s >> (r[2] ? 32'(r) - 4 : 32'(r) + 1));
    endfunction
    task automatic check(logic [31:0] got, logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge sys_clk);
        reg_req <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        reg_req.wr <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge sys_clk);
        reg_req.rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Run takes about 2900 cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        logic [31:0] v, w, s;
        logic k, fr, ie;
        logic [4:0] c, sel;
        int f, i;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        for (int a = 0; a < 16; a++) begin
            rd(4'(a), v);
            check(v, 32'h0);
        end
        w = rnd();
        wr(IDX_MODE, w);
        rd(IDX_MODE, v);
        check(v, w & MODE_MASK);
        check(32'(input_pair_mode), 32'(pick(w, 1)));
        check(32'(twos_complement_select), 32'(pick(w, 0)));
        w = rnd();
        wr(IDX_TRIG, w);
        rd(IDX_TRIG, v);
        check(v, w & TRIG_MASK);
        wr(4'hc, rnd());
        rd(4'hc, v);
        check(v, 32'h0);
        // Every source fires per code; compare sources are held to prove edge use
        for (int t = 0; t < 15; t++) begin
            // Reserved codes are never programmed; the last two passes use no trigger
            c = t < 13 ? tc[t] : TRG_NONE;
            i = t % 4;
            wr(IDX_TRIG, 32'(c) << (8 * i));
            #1 hit = '{default: 8'h0};
            for (int b = 0; b < 12; b++) begin
                u_adc_core_model.fire(b, (b > 0 && b < 6) ? 3 : 1);
            end
            repeat (3) @(posedge sys_clk);
            #1;
            for (int j = 0; j < 4; j++) begin
                check(32'(hit[j]), 32'(j == i && |c));
            end
        end
        for (int m = 0; m < 16; m++) begin
            w = rnd();
            k = m[3];
            f = m % 6;
            fr = w[0] | (m == 14);
            ie = w[1];
            sel = w[20:16];
            wr(IDX_CONFIG, {31'h0, fr});
            w = {1'b1, w[2] | (m == 14), k, 3'(m), ie, 1'b0, 3'h0, sel, 16'h0};
            wr(IDX_FILT_BASE + 4'(f), w);
            s = 0;
            for (int n = 0; n < ns(k, 3'(m)); n++) begin
                v = rnd() & 32'hfff;
                if (n == 1) u_adc_core_model.send({1'b1, sel}, v[11:0]);
                u_adc_core_model.send({1'b0, sel}, v[11:0]);
                s += v;
            end
            repeat (2) @(posedge sys_clk);
            #1 check(32'(filter_irq[f]), 32'(ie));
            if (m[2:0] == 3'd5) wr(IDX_FILT_BASE + 4'(f), 32'h0);
            rd(IDX_FILT_BASE + 4'(f), v);
            check(v & FILT_CTL_MASK, m[2:0] == 3'd5 ? 32'h0 : w & FILT_CTL_MASK);
            check(32'(v[24]), 32'(m[2:0] != 3'd5));
            if (m[2:0] != 3'd5) begin
                s = 32'(exp_res(k, 3'(m), fr, w[30], s));
                check(32'(v[15:0]), s);
            end
            rd(IDX_FILT_BASE + 4'(f), v);
            check(32'(v[24]), 32'h0);
        end
        finish_test();
    end
endmodule
